// ### core/sdh_clkgen.sv
// Card clock divider with glitch-free stop and stable indication
`timescale 1ns/100ps
module sdh_clkgen (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic ce_i, // Clock enable, freezes state when low
    input wire logic en_i, // card_clock_enable
    input wire logic [7:0] div_i, // Half period minus one, in clk_i cycles
    input wire logic pause_i, // FIFO clock pause request
    output logic clk_o, // Card clock
    output logic rise_o, // One cycle pulse in the same cycle as each card clock rising edge
    output logic stable_o // card_clock_stable
);
    logic [7:0] cnt_ff;
    logic [7:0] div_ff;
    logic clk_ff;
    logic rise_ff;
    logic stable_ff;
    wire run = (en_i & ~pause_i) | clk_ff; // A high phase always completes
    wire toggle = run & (cnt_ff >= div_ff);

    // Divider counter; stops only in the low phase so no short pulse escapes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 8'h00;
            div_ff <= 8'h00;
            clk_ff <= 1'b0;
            rise_ff <= 1'b0;
        end else if (ce_i) begin
            rise_ff <= toggle & ~clk_ff;
            if (toggle) begin
                cnt_ff <= 8'h00;
                clk_ff <= ~clk_ff;
                div_ff <= div_i;
            end else if (run) begin
                cnt_ff <= cnt_ff + 8'h01;
            end else begin
                cnt_ff <= 8'h00;
                div_ff <= div_i;
            end
        end
    end

    // Stable once a full half period ran with the current divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stable_ff <= 1'b0;
        end else if (ce_i) begin
            if (!en_i || div_i != div_ff) begin
                stable_ff <= 1'b0;
            end else if (toggle) begin
                stable_ff <= 1'b1;
            end
        end
    end

    assign clk_o = clk_ff;
    assign rise_o = rise_ff;
    assign stable_o = stable_ff;
endmodule : sdh_clkgen

// ### core/sdh_host.sv
// Card host controller core: register slave, card clock, read data path, ADMA2 and card interrupt
// Operation
// - The controller drives the card clock and runs every link transfer.
// - Any reset abandons the command or data operation in progress.
// - Card clock pauses while the data FIFO is full during a transfer.
// - ADMA2 knows transfer, link, no-op descriptors; End bit marks the last.
// - Card interrupt flag sets from DAT1 low with enables; write one clears.
// - Clearing DAT3 detect forces inverted DAT1 low; setting re-arms its edge.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module sdh_host
    import sdh_pkg::*;
#(
    parameter int FIFO_DEPTH = 4 // Data FIFO depth in bytes
) (
    input wire logic clk_i, // System clock, 125 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic ce_i, // Clock enable
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    output logic irq_o, // Interrupt, level
    output logic sd_clk_o, // Card clock
    input wire logic sd_dat0_i, // Card DAT0, read data
    input wire logic sd_dat1_i // Card DAT1, interrupt line
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);
    localparam int PW = $clog2(FIFO_DEPTH);

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    logic ack_ff;
    logic [31:0] rdat_ff;
    logic irq_ff;
    logic [31:0] ctrl_ff;
    logic [31:0] attr_ff;
    logic block_count_enable_bit_ff;
    logic dat3_card_detect_bit_ff;
    logic [SDH_IRQ_W-1:0] st_ff;
    logic [SDH_IRQ_W-1:0] sten_ff;
    logic [SDH_IRQ_W-1:0] sgen_ff;
    logic [1:0] last_act_ff;
    logic end_seen_ff;
    logic [31:0] adma_len_ff;
    logic [1:0] d0_sync_ff;
    logic [1:0] d1_sync_ff;
    logic inv_d1_ff;
    sdh_state_t state_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [SDH_BSIZE_W-1:0] byte_cnt_ff;
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [LW-1:0] lvl_ff;
    logic card_rise;
    logic clk_stable;
    logic card_clk;

    // Bus decode
    wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wr = req & wb_we_i;
    wire rd = req & ~wb_we_i;
    wire wr_ctrl = wr && wb_adr_i == SDH_SYS_CTRL;
    wire wr_attr = wr && wb_adr_i == SDH_BLK_ATTR;
    wire wr_xfer = wr && wb_adr_i == SDH_XFER;
    wire wr_proto = wr && wb_adr_i == SDH_PROTO;
    wire wr_st = wr && wb_adr_i == SDH_IRQ_ST;
    wire wr_sten = wr && wb_adr_i == SDH_IRQ_STEN;
    wire wr_sgen = wr && wb_adr_i == SDH_IRQ_SGEN;
    wire wr_desc = wr && wb_adr_i == SDH_ADMA_DESC && wb_sel_i[0];
    wire [31:0] ctrl_new = merge(ctrl_ff, wb_dat_i, wb_sel_i);
    wire [31:0] attr_new = merge(attr_ff, wb_dat_i, wb_sel_i);

    // Soft reset is a one cycle strobe, never stored
    wire soft_rst = wr_ctrl & wb_sel_i[3] & wb_dat_i[SDH_SRST_BIT];
    wire start = wr_xfer & wb_sel_i[0] & wb_dat_i[SDH_START_BIT];
    wire start_block_count_enable_bit = wb_dat_i[SDH_BLOCK_COUNT_ENABLE_BIT_BIT];

    // FIFO status
    wire fifo_full = lvl_ff == LW'(FIFO_DEPTH);
    wire fifo_empty = lvl_ff == '0;
    wire pop = rd && wb_adr_i == SDH_DATA && !fifo_empty;
    wire running = state_ff == SDH_ST_RUN;
    wire fifo_pause = running & fifo_full;

    // Read data path
    wire [SDH_BSIZE_W-1:0] blk_size = attr_ff[SDH_BSIZE_W-1:0];
    wire [15:0] blk_cnt = attr_ff[SDH_BCNT_LSB +: 16];
    wire sample = running & card_rise;
    wire byte_done = sample && bit_cnt_ff == 3'h7;
    wire blk_done = byte_done && byte_cnt_ff == blk_size - SDH_BSIZE_W'(1);
    wire last_blk = !block_count_enable_bit_ff || blk_cnt == 16'h0001;
    wire xfer_end = (blk_done && last_blk) || (start && start_block_count_enable_bit && blk_cnt == 16'h0000);
    wire push = byte_done;

    // Interrupt events
    wire card_interrupt_flag_en = sten_ff[SDH_CARD_INTERRUPT_FLAG_BIT] & sgen_ff[SDH_CARD_INTERRUPT_FLAG_BIT];
    wire inv_d1 = dat3_card_detect_bit_ff & ~d1_sync_ff[1];
    wire card_interrupt_flag_ev = inv_d1 & ~inv_d1_ff & card_interrupt_flag_en;
    wire desc_valid = wr_desc & wb_dat_i[SDH_DV_BIT];
    wire [1:0] desc_act = wb_dat_i[SDH_ACT_LSB +: 2];
    wire desc_end = desc_valid & wb_dat_i[SDH_DEND_BIT];
    wire [SDH_IRQ_W-1:0] ev = {card_interrupt_flag_ev, desc_end, xfer_end};
    wire [SDH_IRQ_W-1:0] clr = wr_st && wb_sel_i[0] ? wb_dat_i[SDH_IRQ_W-1:0] : '0;
    wire [SDH_IRQ_W-1:0] st_next = (st_ff & ~clr) | (ev & sten_ff); // Set wins

    // Register read mux
    wire [31:0] present = {16'h0000, {(8-LW){1'b0}}, lvl_ff, 4'h0,
        clk_stable, d1_sync_ff[1], fifo_pause, running};
    wire [31:0] rd_word =
        wb_adr_i == SDH_SYS_CTRL ? ctrl_ff :
        wb_adr_i == SDH_PRESENT ? present :
        wb_adr_i == SDH_BLK_ATTR ? attr_ff :
        wb_adr_i == SDH_XFER ? {30'h0, block_count_enable_bit_ff, 1'b0} :
        wb_adr_i == SDH_PROTO ? {24'h0, dat3_card_detect_bit_ff, 7'h00} :
        wb_adr_i == SDH_IRQ_ST ? {29'h0, st_ff} :
        wb_adr_i == SDH_IRQ_STEN ? {29'h0, sten_ff} :
        wb_adr_i == SDH_IRQ_SGEN ? {29'h0, sgen_ff} :
        wb_adr_i == SDH_DATA ? {24'h0, fifo_empty ? 8'h00 : fifo_mem[rd_ptr_ff]} :
        wb_adr_i == SDH_ADMA_DESC ? {26'h0, last_act_ff, 3'h0, end_seen_ff} :
        wb_adr_i == SDH_ADMA_LEN ? adma_len_ff : 32'h0000_0000;

    // Card clock generator, host is always the clock source
    sdh_clkgen u_clkgen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .en_i(ctrl_ff[SDH_CLKEN_BIT]),
        .div_i(ctrl_ff[SDH_DIV_LSB +: 8]),
        .pause_i(fifo_pause),
        .clk_o(card_clk),
        .rise_o(card_rise),
        .stable_o(clk_stable)
    );

    // Bus handshake, one cycle answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
        end else if (ce_i) begin
            ack_ff <= req;
            rdat_ff <= rd ? rd_word : 32'h0000_0000;
            irq_ff <= |(st_ff & sgen_ff);
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            d0_sync_ff <= 2'h3;
            d1_sync_ff <= 2'h3;
            inv_d1_ff <= 1'b0;
        end else if (ce_i) begin
            d0_sync_ff <= {d0_sync_ff[0], sd_dat0_i};
            d1_sync_ff <= {d1_sync_ff[0], sd_dat1_i};
            inv_d1_ff <= inv_d1;
        end
    end

    // Software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= {16'h0000, SDH_DIV_RST, 8'h00};
            dat3_card_detect_bit_ff <= SDH_DAT3_CARD_DETECT_BIT_RST;
            sten_ff <= '0;
            sgen_ff <= '0;
            st_ff <= '0;
        end else if (ce_i) begin
            if (wr_ctrl) ctrl_ff <= {8'h00, ctrl_new[23:0]};
            if (wr_proto && wb_sel_i[0]) dat3_card_detect_bit_ff <= wb_dat_i[SDH_DAT3_CARD_DETECT_BIT_BIT];
            if (wr_sten && wb_sel_i[0]) sten_ff <= wb_dat_i[SDH_IRQ_W-1:0];
            if (wr_sgen && wb_sel_i[0]) sgen_ff <= wb_dat_i[SDH_IRQ_W-1:0];
            st_ff <= st_next;
        end
    end

    // ADMA2 descriptor tracking
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && soft_rst)) begin
            last_act_ff <= SDH_ACT_NOP;
            end_seen_ff <= 1'b0;
            adma_len_ff <= 32'h0000_0000;
        end else if (ce_i && desc_valid) begin
            if (desc_act == SDH_ACT_TRAN) begin
                adma_len_ff <= adma_len_ff + {16'h0000, wb_dat_i[SDH_DLEN_LSB +: 16]};
            end
            last_act_ff <= desc_act;
            end_seen_ff <= desc_end;
        end
    end

    // Transfer state and block count
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && soft_rst)) begin
            state_ff <= SDH_ST_IDLE;
            block_count_enable_bit_ff <= 1'b0;
            attr_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            if (wr_attr) attr_ff <= {attr_new[31:16], 3'h0, attr_new[SDH_BSIZE_W-1:0]};
            if (start) block_count_enable_bit_ff <= start_block_count_enable_bit;
            if (xfer_end) begin
                state_ff <= SDH_ST_IDLE;
            end else if (start) begin
                state_ff <= SDH_ST_RUN;
            end
            if (blk_done && block_count_enable_bit_ff) begin
                attr_ff[SDH_BCNT_LSB +: 16] <= blk_cnt - 16'h0001;
            end
        end
    end

    // Bit and byte assembly
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && (soft_rst || start))) begin
            bit_cnt_ff <= 3'h0;
            shift_ff <= 8'h00;
            byte_cnt_ff <= '0;
        end else if (ce_i && sample) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            shift_ff <= {shift_ff[6:0], d0_sync_ff[1]};
            if (byte_done) begin
                byte_cnt_ff <= blk_done ? '0 : byte_cnt_ff + SDH_BSIZE_W'(1);
            end
        end
    end

    // Data FIFO pointers and level
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && soft_rst)) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            lvl_ff <= '0;
        end else if (ce_i) begin
            if (push) wr_ptr_ff <= wr_ptr_ff == PW'(FIFO_DEPTH - 1) ? '0 : wr_ptr_ff + PW'(1);
            if (pop) rd_ptr_ff <= rd_ptr_ff == PW'(FIFO_DEPTH - 1) ? '0 : rd_ptr_ff + PW'(1);
            lvl_ff <= lvl_ff + LW'(push) - LW'(pop);
        end
    end

    // Data FIFO storage
    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            fifo_mem[wr_ptr_ff] <= {shift_ff[6:0], d0_sync_ff[1]};
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign irq_o = irq_ff;
    assign sd_clk_o = card_clk;

    // Checks
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req) |=> wb_ack_o) else $error("request not acknowledged next cycle");
    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> irq_o == $past(|(st_ff & sgen_ff))) else $error("irq does not follow masked status");
    soft_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && soft_rst) |=> (state_ff == SDH_ST_IDLE && lvl_ff == '0)) else $error("soft reset left transfer");
    fifo_pause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && fifo_pause && !sd_clk_o) |=> !card_rise) else $error("card clock ran with full FIFO");
    blk_decr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && blk_done && block_count_enable_bit_ff && !soft_rst && !wr_attr) |=> blk_cnt == $past(blk_cnt) - 16'h0001)
        else $error("block count not decremented");
    blk_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && blk_done && block_count_enable_bit_ff && blk_cnt == 16'h0001 && sten_ff[SDH_TC_BIT] && !soft_rst)
        |=> (state_ff == SDH_ST_IDLE && st_ff[SDH_TC_BIT])) else $error("transfer not ended at zero");
    card_interrupt_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && card_interrupt_flag_ev && sten_ff[SDH_CARD_INTERRUPT_FLAG_BIT]) |=> st_ff[SDH_CARD_INTERRUPT_FLAG_BIT]) else $error("card interrupt lost");
    dat3_card_detect_bit_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!dat3_card_detect_bit_ff && !$past(dat3_card_detect_bit_ff)) |-> !card_interrupt_flag_ev) else $error("card interrupt with detect cleared");
    adma_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && desc_end && sten_ff[SDH_DMA_DONE_FLAG_BIT]) |=> (st_ff[SDH_DMA_DONE_FLAG_BIT] && end_seen_ff))
        else $error("end descriptor did not raise dma done");
endmodule : sdh_host

// ### shared/sdh_pkg.sv
// Package: register map, field positions and encodings of the card host block
package sdh_pkg;
    // Register byte offsets
    localparam logic [7:0] SDH_SYS_CTRL = 8'h00; // System control
    localparam logic [7:0] SDH_PRESENT = 8'h04; // Present state
    localparam logic [7:0] SDH_BLK_ATTR = 8'h08; // block_attributes_register
    localparam logic [7:0] SDH_XFER = 8'h0c; // Transfer start and mode
    localparam logic [7:0] SDH_PROTO = 8'h10; // protocol_control_register
    localparam logic [7:0] SDH_IRQ_ST = 8'h14; // irq_status_register
    localparam logic [7:0] SDH_IRQ_STEN = 8'h18; // irq_status_enable_register
    localparam logic [7:0] SDH_IRQ_SGEN = 8'h1c; // irq_signal_enable_register
    localparam logic [7:0] SDH_DATA = 8'h20; // Read data port, pops one byte
    localparam logic [7:0] SDH_ADMA_DESC = 8'h24; // ADMA2 descriptor attribute word
    localparam logic [7:0] SDH_ADMA_LEN = 8'h28; // Bytes announced by transfer descriptors
    // System control fields
    localparam int SDH_CLKEN_BIT = 3; // card_clock_enable
    localparam int SDH_SRST_BIT = 24; // full_soft_reset, self clearing
    localparam int SDH_GATE_BIT = 0; // sys_clock_gate_override
    localparam int SDH_DIV_LSB = 8; // Card clock divider, 8 bits
    // Present state fields
    localparam int SDH_STABLE_BIT = 3; // card_clock_stable
    localparam int SDH_BUSY_BIT = 0; // Data transfer running
    localparam int SDH_PAUSE_BIT = 1; // FIFO clock paused
    localparam int SDH_DAT1_BIT = 2; // Synchronised DAT1 level
    localparam int SDH_LVL_LSB = 8; // FIFO fill level
    // Block attributes fields
    localparam int SDH_BSIZE_W = 13; // Block size in bytes
    localparam int SDH_BCNT_LSB = 16; // block_count_field
    // Transfer register fields
    localparam int SDH_START_BIT = 0; // Start a read transfer
    localparam int SDH_BLOCK_COUNT_ENABLE_BIT_BIT = 1; // block_count_enable_bit
    // Protocol control fields
    localparam int SDH_DAT3_CARD_DETECT_BIT_BIT = 7; // dat3_card_detect_bit
    // Interrupt status bits, same layout in both enable registers
    localparam int SDH_TC_BIT = 0; // transfer_complete_flag
    localparam int SDH_DMA_DONE_FLAG_BIT = 1; // dma_done_flag
    localparam int SDH_CARD_INTERRUPT_FLAG_BIT = 2; // card_interrupt_flag
    localparam int SDH_IRQ_W = 3;
    // ADMA2 descriptor attribute fields and action codes
    localparam int SDH_DV_BIT = 0; // Valid
    localparam int SDH_DEND_BIT = 1; // End of set
    localparam int SDH_ACT_LSB = 4; // Two bit action
    localparam int SDH_DLEN_LSB = 16; // Length
    localparam logic [1:0] SDH_ACT_NOP = 2'h0;
    localparam logic [1:0] SDH_ACT_TRAN = 2'h2;
    localparam logic [1:0] SDH_ACT_LINK = 2'h3;
    // Reset values
    localparam logic [7:0] SDH_DIV_RST = 8'h04;
    localparam logic SDH_DAT3_CARD_DETECT_BIT_RST = 1'b1;
    // Transfer states
    typedef enum logic [0:0] {
        SDH_ST_IDLE = 1'b0,
        SDH_ST_RUN = 1'b1
    } sdh_state_t;
endpackage : sdh_pkg

// ### verif/sdh_card_model.sv
// Behavioural card: streams a byte pattern on DAT0 and pulls DAT1 low on request
`timescale 1ns/100ps
module sdh_card_model (
    input wire logic sd_clk_i, // Card clock from the host
    input wire logic restart_i, // High holds the card idle, stream restarts at byte 0
    input wire logic irq_req_i, // Raise a card interrupt
    output logic sd_dat0_o, // Read data
    output logic sd_dat1_o // Interrupt line
);
    logic [7:0] idx_ff;
    logic [2:0] bit_ff;
    logic [7:0] cur;
    // Byte under transmission and its current bit, MSB first
    assign cur = idx_ff * 8'h1d + 8'h47;
    assign sd_dat0_o = restart_i ? 1'b1 : cur[3'd7 - bit_ff]; // Idle line rests at pull-up
    // Open-drain interrupt, released line floats high
    assign sd_dat1_o = irq_req_i ? 1'b0 : 1'b1;
    // Next bit after each falling card clock edge, paced only by the host
    always @(negedge sd_clk_i or posedge restart_i) begin
        if (restart_i) begin
            idx_ff <= 8'h0;
            bit_ff <= 3'h0;
        end else begin
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
                idx_ff <= idx_ff + 8'h1;
            end
        end
    end
endmodule : sdh_card_model

// ### verif/sdh_host_tb.sv
// Self-checking bench for the card host block
`timescale 1ns/100ps
module sdh_host_tb;
    import sdh_pkg::*;
    localparam logic W = 1'b1;
    localparam logic R = 1'b0;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic restart = 1'b1;
    logic dat1_req = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o, sd_clk_o, dat0, dat1;
    logic [1:0] acts [3] = '{SDH_ACT_NOP, SDH_ACT_TRAN, SDH_ACT_LINK};
    int mismatches = 0;
    int samples_checked = 0;
    // Free running system clock
    always #4 clk_i = ~clk_i;
    sdh_host u_sdh_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .sd_clk_o(sd_clk_o), .sd_dat0_i(dat0), .sd_dat1_i(dat1));
    sdh_card_model u_sdh_card_model (.sd_clk_i(sd_clk_o), .restart_i(restart), .irq_req_i(dat1_req),
        .sd_dat0_o(dat0), .sd_dat1_o(dat1));
    // Verdict and end of run
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Compare and report
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Expected card byte at stream position k
    function automatic logic [7:0] pat(input int k);
        return 8'(k) * 8'h1d + 8'h47;
    endfunction : pat
    // One classic Wishbone cycle, read data left in rd
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask : wb
    // Poll a register until masked value equals v (ne: until it differs)
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input bit ne);
        int n;
        n = 0;
        do begin
            wb(R, a, 32'h0);
            n++;
        end while ((((rd & m) === v) == ne) && n < 3000);
        if (((rd & m) === v) == ne) begin
            mismatches++;
            summarize();
        end
    endtask : poll
    // Wait for a card clock level, counting system clocks
    task automatic lvl(input logic v, inout int n);
        do begin
            @(posedge clk_i);
            n++;
        end while (sd_clk_o !== v && n < 200);
        if (n >= 200) begin
            mismatches++;
            summarize();
        end
    endtask : lvl
    // Card clock period from rise to rise
    task automatic period(input int exp);
        int n;
        n = 0;
        lvl(1'b0, n);
        lvl(1'b1, n);
        n = 0;
        lvl(1'b0, n);
        lvl(1'b1, n);
        chk("card clock period", n, exp);
    endtask : period
    // Read transfer of sz byte blocks, cn of them when bc is set, else one; ie is the expected interrupt level
    task automatic xfer(input int sz, input int cn, input logic bc, input logic ie);
        int nb;
        logic s;
        nb = bc ? sz * cn : sz;
        wb(W, SDH_SYS_CTRL, 32'h0000_0401); // Clock off, gate override on
        restart <= 1'b1;
        wb(W, SDH_IRQ_SGEN, {31'h0, ie});
        wb(W, SDH_BLK_ATTR, {16'(cn), 16'(sz)});
        wb(W, SDH_XFER, {30'h0, bc, 1'b1});
        restart <= 1'b0;
        wb(W, SDH_SYS_CTRL, 32'h0000_0409);
        // Only a transfer longer than the FIFO is still running when the FIFO fills
        if (nb > 4) begin
            poll(SDH_PRESENT, 32'h2, 32'h2, 1'b0); // Drain only once full
            chk("full fifo", rd & 32'h0702, 32'h0402);
            repeat (8) @(posedge clk_i);
            s = sd_clk_o;
            chk("clock parked low", {31'h0, s}, 32'h0);
            repeat (16) @(posedge clk_i);
            chk("clock held", {31'h0, sd_clk_o}, {31'h0, s});
        end
        for (int j = 0; j < nb; j++) begin
            poll(SDH_PRESENT, 32'h0700, 32'h0, 1'b1);
            wb(R, SDH_DATA, 32'h0);
            chk("data byte", rd, {24'h0, pat(j)});
        end
        poll(SDH_PRESENT, 32'h1, 32'h0, 1'b0);
        chk("nothing left", rd & 32'h0701, 32'h0);
        wb(R, SDH_IRQ_ST, 32'h0);
        chk("done flag", rd & 32'h1, 32'h1);
        chk("irq level", {31'h0, irq_o}, {31'h0, ie});
        wb(R, SDH_BLK_ATTR, 32'h0);
        if (bc) chk("count left", rd >> 16, 32'h0);
        wb(W, SDH_IRQ_ST, 32'h1);
        wb(W, SDH_SYS_CTRL, 32'h0000_0400); // Override dropped, clock stopped
        chk("irq cleared", {31'h0, irq_o}, 32'h0);
    endtask : xfer
    // Main sequence
    initial begin
        void'($urandom(77));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(R, SDH_SYS_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0000_0400);
        wb(R, SDH_PROTO, 32'h0);
        chk("detect reset", rd & 32'h80, 32'h80);
        wb(R, 8'h3c, 32'h0);
        chk("unmapped read", rd, 32'h0);
        wb(W, SDH_IRQ_STEN, 32'h1);
        xfer(5, 3, 1'b0, 1'b1); // Single block without counting
        xfer(4, 0, 1'b0 | 1'b1, 1'b0); // Zero count, masked interrupt
        repeat (3) xfer($urandom_range(4, 1), $urandom_range(3, 1), 1'b1, 1'b1);
        // Card interrupt: seen live, then missed while disabled and re-armed by detect toggle
        wb(W, SDH_IRQ_SGEN, 32'h4);
        for (int i = 0; i < 2; i++) begin
            wb(W, SDH_IRQ_STEN, {29'h0, i == 0, 2'h0});
            dat1_req <= 1'b1;
            repeat (8) @(posedge clk_i);
            wb(W, SDH_IRQ_STEN, 32'h4);
            wb(R, SDH_IRQ_ST, 32'h0);
            chk("card flag", rd & 32'h4, i == 0 ? 32'h4 : 32'h0);
            wb(W, SDH_IRQ_ST, 32'h4);
            wb(W, SDH_PROTO, 32'h0); // Handler toggles detect to re-arm
            repeat (8) @(posedge clk_i);
            wb(R, SDH_IRQ_ST, 32'h0);
            chk("detect off", rd & 32'h4, 32'h0);
            wb(W, SDH_PROTO, 32'h80);
            repeat (8) @(posedge clk_i);
            chk("card irq", {31'h0, irq_o}, 32'h1);
            wb(W, SDH_IRQ_ST, 32'h4);
            dat1_req <= 1'b0;
            repeat (8) @(posedge clk_i);
        end
        // Every descriptor kind as last of a set, dma done enabled
        wb(W, SDH_IRQ_STEN, 32'h2);
        foreach (acts[i]) begin
            wb(W, SDH_SYS_CTRL, 32'h0100_0400);
            wb(W, SDH_ADMA_DESC, {16'h0004, 10'h0, acts[i], 4'h3});
            wb(R, SDH_ADMA_DESC, 32'h0);
            chk("last kind", rd & 32'h31, {26'h0, acts[i], 4'h1});
        end
        wb(W, SDH_SYS_CTRL, 32'h0100_0400);
        wb(W, SDH_ADMA_DESC, 32'h0005_0021);
        wb(W, SDH_ADMA_DESC, 32'h0000_0031);
        wb(W, SDH_ADMA_DESC, 32'h0000_0001);
        wb(R, SDH_ADMA_DESC, 32'h0);
        chk("no end yet", rd & 32'h1, 32'h0);
        wb(W, SDH_ADMA_DESC, 32'h0007_0023); // Chain closes on a transfer descriptor
        wb(R, SDH_ADMA_DESC, 32'h0);
        chk("end seen", rd & 32'h31, 32'h21);
        wb(R, SDH_ADMA_LEN, 32'h0);
        chk("length sum", rd, 32'd12);
        wb(R, SDH_IRQ_ST, 32'h0);
        chk("dma done", rd & 32'h2, 32'h2);
        // Clock start, stop and divider change
        wb(W, SDH_SYS_CTRL, 32'h0000_0408);
        poll(SDH_PRESENT, 32'h8, 32'h8, 1'b0);
        period(10);
        wb(W, SDH_SYS_CTRL, 32'h0000_0400);
        wb(R, SDH_PRESENT, 32'h0);
        chk("stable off", rd & 32'h8, 32'h0);
        repeat (12) @(posedge clk_i);
        chk("clock parked", {31'h0, sd_clk_o}, 32'h0);
        wb(W, SDH_SYS_CTRL, 32'h0000_0200);
        wb(W, SDH_SYS_CTRL, 32'h0000_0208);
        poll(SDH_PRESENT, 32'h8, 32'h8, 1'b0);
        period(6);
        // Soft reset in mid-transfer
        wb(W, SDH_BLK_ATTR, 32'hffff_0004); // Largest block count, 4 byte blocks
        wb(W, SDH_XFER, 32'h3);
        poll(SDH_PRESENT, 32'h0700, 32'h0, 1'b1);
        wb(W, SDH_SYS_CTRL, 32'h0000_0200); // Clock off before the reset
        wb(W, SDH_SYS_CTRL, 32'h0100_0200);
        wb(R, SDH_PRESENT, 32'h0);
        chk("abandoned", rd & 32'h0701, 32'h0);
        wb(R, SDH_BLK_ATTR, 32'h0);
        chk("attr cleared", rd, 32'h0);
        // Hardware reset in mid-transfer
        wb(W, SDH_BLK_ATTR, 32'hffff_0004);
        wb(W, SDH_XFER, 32'h3);
        wb(W, SDH_SYS_CTRL, 32'h0000_0208);
        poll(SDH_PRESENT, 32'h0700, 32'h0, 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(R, SDH_PRESENT, 32'h0);
        chk("reset abandoned", rd & 32'h0701, 32'h0);
        wb(R, SDH_SYS_CTRL, 32'h0);
        chk("ctrl after reset", rd, 32'h0000_0400);
        summarize();
    end
endmodule : sdh_host_tb
